/* File: design/i2c_timing_map.svh */
// Timing counts and widths for the two-wire serial bit timer.
`ifndef I2C_TIMING_MAP_SVH
`define I2C_TIMING_MAP_SVH

// Width of the phase counter; it must hold the longest phase, 1024 cycles.
`define CNT_W 11

// Every time below is printed in host bus clock cycles. The host bus clock is REF_CLK_I,
// so the cycle count is the printed figure times one clock per host bus cycle.
`define HOST_CYC_PER_BUS_CYC 11'd1

// Serial clock high and low phases; their sum is the 1024-cycle period.
`define T_SCL_HIGH_BUS   11'd512
`define T_SCL_LOW_BUS    11'd512
`define T_SCL_PERIOD_BUS (`T_SCL_HIGH_BUS + `T_SCL_LOW_BUS)
// START setup and hold, STOP setup, bus free time.
`define T_SU_STA_BUS     11'd1024
`define T_HD_STA_BUS     11'd512
`define T_SU_STO_BUS     11'd512
`define T_BUF_BUS        11'd512
// Data output valid, data output hold and data sample point.
`define T_DATA_BUS       11'd256

// Derived cycle counts of REF_CLK_I.
`define T_SCL_HIGH_CYC   (`T_SCL_HIGH_BUS * `HOST_CYC_PER_BUS_CYC)
`define T_SCL_LOW_CYC    (`T_SCL_LOW_BUS * `HOST_CYC_PER_BUS_CYC)
`define T_SU_STA_CYC     (`T_SU_STA_BUS * `HOST_CYC_PER_BUS_CYC)
`define T_HD_STA_CYC     (`T_HD_STA_BUS * `HOST_CYC_PER_BUS_CYC)
`define T_SU_STO_CYC     (`T_SU_STO_BUS * `HOST_CYC_PER_BUS_CYC)
`define T_BUF_CYC        (`T_BUF_BUS * `HOST_CYC_PER_BUS_CYC)
`define T_DATA_CYC       (`T_DATA_BUS * `HOST_CYC_PER_BUS_CYC)

`endif

/* File: design/i2c_timing_pkg.sv */
// Types shared by the serial bit timer and its command crossing.
package i2c_timing_pkg;

  // Bit-level operations that the command side may request.
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP  = 2'h1,
    OP_WRITE = 2'h2,
    OP_READ  = 2'h3
  } bit_op_e;

  // One command: the operation and, for a write, the bit to send.
  typedef struct packed {
    bit_op_e op;
    logic    wbit;
  } bit_cmd_s;

  // One answer: the bit read and a flag for an operation refused in the idle bus.
  typedef struct packed {
    logic rbit;
    logic err;
  } bit_rsp_s;

  // Timer states, one-hot.
  typedef enum logic [9:0] {
    ST_IDLE     = 10'h001,
    ST_START_SU = 10'h002,
    ST_START_HD = 10'h004,
    ST_LOW      = 10'h008,
    ST_RS_LO    = 10'h010,
    ST_BIT_LO   = 10'h020,
    ST_BIT_HI   = 10'h040,
    ST_STOP_LO  = 10'h080,
    ST_STOP_SU  = 10'h100,
    ST_BUS_FREE = 10'h200
  } timer_state_e;

endpackage

/* File: design/i2c_cmd_cdc.sv */
// Toggle handshake that carries commands into the timer clock and answers back.
`timescale 1ns/1ps
module i2c_cmd_cdc (
  // Clocks and reset.
  input  wire logic                     src_clk_i,
  input  wire logic                     dst_clk_i,
  input  wire logic                     rst_i,
  // Command side, on src_clk_i.
  input  wire logic                     src_valid_i,
  output logic                          src_ready_o,
  input  wire i2c_timing_pkg::bit_cmd_s src_cmd_i,
  output logic                          src_rsp_valid_o,
  output i2c_timing_pkg::bit_rsp_s      src_rsp_o,
  // Timer side, on dst_clk_i.
  output logic                          dst_valid_o,
  output i2c_timing_pkg::bit_cmd_s      dst_cmd_o,
  input  wire logic                     dst_done_i,
  input  wire i2c_timing_pkg::bit_rsp_s dst_rsp_i
);
  import i2c_timing_pkg::*;

  logic     busy_q;                   // A command is in flight.
  logic     req_tgl_q;                // Flips once per command.
  bit_cmd_s cmd_q;                    // Held stable while in flight.
  logic     a1_q, a2_q, a3_q, ack_lvl_q;
  logic     rsp_valid_q;
  bit_rsp_s rsp_q;
  logic     r1_q, r2_q, r3_q, req_lvl_q;
  logic     ack_tgl_q;                // Flips once per answer.
  bit_rsp_s drsp_q;                   // Held stable until the next answer.
  wire      ack_new = (a2_q == a3_q) && (a3_q != ack_lvl_q);
  wire      req_new = (r2_q == r3_q) && (r3_q != req_lvl_q);
  wire      take    = src_valid_i && !busy_q;

  // Only one command may be in flight, so the held payload never changes under the far side.
  assign src_ready_o     = !busy_q;
  assign src_rsp_valid_o = rsp_valid_q;
  assign src_rsp_o       = rsp_q;
  assign dst_valid_o     = req_new;
  assign dst_cmd_o       = cmd_q;

  // Source side: launch a command, then wait for the answer toggle.
  always_ff @(posedge src_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {busy_q, req_tgl_q, a1_q, a2_q, a3_q, ack_lvl_q, rsp_valid_q} <= 7'h00;
      cmd_q <= '0;
      rsp_q <= '0;
    end else begin
      {a1_q, a2_q, a3_q} <= {ack_tgl_q, a1_q, a2_q};
      rsp_valid_q <= ack_new;
      if (take) begin
        cmd_q     <= src_cmd_i;
        req_tgl_q <= ~req_tgl_q;
      end
      if (ack_new) begin
        ack_lvl_q <= a3_q;
        rsp_q     <= drsp_q;
      end
      busy_q <= take | (busy_q & ~ack_new);
    end
  end

  // Timer side: a change counts once the second and third stages agree.
  always_ff @(posedge dst_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {r1_q, r2_q, r3_q, req_lvl_q, ack_tgl_q} <= 5'h00;
      drsp_q <= '0;
    end else begin
      {r1_q, r2_q, r3_q} <= {req_tgl_q, r1_q, r2_q};
      if (req_new) begin
        req_lvl_q <= r3_q;
      end
      if (dst_done_i) begin
        ack_tgl_q <= ~ack_tgl_q;
        drsp_q    <= dst_rsp_i;
      end
    end
  end

endmodule // i2c_cmd_cdc

/* File: design/i2c_bit_timer.sv */
// Two-wire serial master bit timer, counted on the host bus clock.
// Contract
// - Serial clock period 1024, high 512, low 512.
// - STOP: clock high 512 before data release.
// - START: clock high 1024 before data low.
// - START: data low 512 before clock low.
// - New data bit 256 after clock fall.
// - Data held 256 past clock fall.
// - Sample data 256 after clock rise.
`timescale 1ns/1ps
`include "i2c_timing_map.svh"
module i2c_bit_timer (
  // Host bus clock and power-up reset.
  input  wire logic                     REF_CLK_I,
  input  wire logic                     RST_I,
  // Command side clock.
  input  wire logic                     CMD_CLK_I,
  // Command request and answer, on CMD_CLK_I.
  input  wire logic                     CMD_VALID_I,
  output logic                          CMD_READY_O,
  input  wire i2c_timing_pkg::bit_cmd_s CMD_I,
  output logic                          RSP_VALID_O,
  output i2c_timing_pkg::bit_rsp_s      RSP_O,
  // Serial clock pin, open drain.
  input  wire logic                     SCL_I,
  output logic                          SCL_O,
  output logic                          SCL_OE_N_O,
  // Serial data pin, open drain.
  input  wire logic                     SDA_I,
  output logic                          SDA_O,
  output logic                          SDA_OE_N_O
);
  import i2c_timing_pkg::*;

  // True in the last cycle of a phase of the given length.
  function automatic logic hit(input logic [`CNT_W-1:0] cnt, input logic [`CNT_W-1:0] len);
    return cnt == (len - `CNT_W'(1));
  endfunction

  timer_state_e      state_q, state_d;      // Phase of the serial bus.
  logic [`CNT_W-1:0] cnt_q, cnt_d;          // Cycles spent in the current phase.
  logic              scl_drv_q, scl_d;      // High while the clock line is pulled low.
  logic              sda_drv_q, sda_d;      // High while the data line is pulled low.
  bit_cmd_s          cmd_q;                 // Latest command from the crossing.
  logic              pend_q;                // Command waiting to be started.
  logic              rd_q, rd_d;            // A read waits for its sample point.
  logic              done_q, done_d;        // Answer pulse to the crossing.
  bit_rsp_s          rsp_q, rsp_d;          // Answer payload.
  logic              take;                  // The pending command is consumed.
  logic              new_cmd;               // Command arrives from the crossing.
  bit_cmd_s          new_cmd_val;           // Its payload.
  logic [1:0]        s1_q, s2_q, s3_q;      // Pin synchronisers: {data, clock}.
  logic [1:0]        lvl_q;                 // Filtered pin levels.
  wire  [1:0]        pin_raw = {SDA_I, SCL_I};
  wire               sda_lvl = lvl_q[1];
  wire               bus_idle = &lvl_q;      // Both lines seen high.

  // The lines are only ever pulled low; the pad resolves the released level.
  assign SCL_O      = 1'b0;
  assign SDA_O      = 1'b0;
  assign SCL_OE_N_O = ~scl_drv_q;
  assign SDA_OE_N_O = ~sda_drv_q;

  // Command crossing between the command clock and the host bus clock.
  i2c_cmd_cdc u_cdc (
    .src_clk_i       (CMD_CLK_I),
    .dst_clk_i       (REF_CLK_I),
    .rst_i           (RST_I),
    .src_valid_i     (CMD_VALID_I),
    .src_ready_o     (CMD_READY_O),
    .src_cmd_i       (CMD_I),
    .src_rsp_valid_o (RSP_VALID_O),
    .src_rsp_o       (RSP_O),
    .dst_valid_o     (new_cmd),
    .dst_cmd_o       (new_cmd_val),
    .dst_done_i      (done_q),
    .dst_rsp_i       (rsp_q)
  );

  // Pins pass three stages; a level counts once the second and third agree.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
          s1_q[g]  <= 1'b1;
          s2_q[g]  <= 1'b1;
          s3_q[g]  <= 1'b1;
          lvl_q[g] <= 1'b1;
        end else begin
          s1_q[g] <= pin_raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            lvl_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  // The counter restarts on each change of phase and stands still while waiting.
  wire cnt_hold = (state_q == ST_LOW) && hit(cnt_q, `T_DATA_CYC);
  assign cnt_d = ((state_d != state_q) || (state_q == ST_IDLE)) ? '0 :
                 cnt_hold ? cnt_q : cnt_q + `CNT_W'(1);

  // Phase sequencing. Each branch but ST_IDLE holds the lines until its phase count is reached.
  always_comb begin
    state_d = state_q;
    scl_d   = scl_drv_q;
    sda_d   = sda_drv_q;
    take    = 1'b0;
    done_d  = 1'b0;
    rsp_d   = rsp_q;
    rd_d    = rd_q;
    unique case (state_q)
      ST_IDLE: begin
        // A new transfer may only begin with START on a quiet bus.
        if (pend_q) begin
          if (cmd_q.op == OP_START) begin
            if (bus_idle) begin
              state_d = ST_START_SU;
              take    = 1'b1;
              done_d  = 1'b1;
              rsp_d   = '{rbit: 1'b0, err: 1'b0};
            end
          end else begin
            // Data bits outside a transfer are refused; a STOP here is harmless.
            take   = 1'b1;
            done_d = 1'b1;
            rsp_d  = '{rbit: 1'b0, err: (cmd_q.op != OP_STOP)};
          end
        end
      end
      ST_START_SU: begin
        if (hit(cnt_q, `T_SU_STA_CYC)) begin
          sda_d   = 1'b1;
          state_d = ST_START_HD;
        end
      end
      ST_START_HD: begin
        if (hit(cnt_q, `T_HD_STA_CYC)) begin
          scl_d   = 1'b1;
          state_d = ST_LOW;
        end
      end
      ST_LOW: begin
        // The data line may change only after the hold time past the falling edge.
        if (hit(cnt_q, `T_DATA_CYC) && pend_q) begin
          take   = 1'b1;
          done_d = (cmd_q.op != OP_READ);
          rsp_d  = '{rbit: 1'b0, err: 1'b0};
          unique case (cmd_q.op)
            OP_START: begin
              sda_d   = 1'b0;
              state_d = ST_RS_LO;
            end
            OP_STOP: begin
              sda_d   = 1'b1;
              state_d = ST_STOP_LO;
            end
            OP_WRITE: begin
              sda_d   = ~cmd_q.wbit;
              state_d = ST_BIT_LO;
            end
            OP_READ: begin
              // Released so the target can drive while the clock is low.
              sda_d   = 1'b0;
              rd_d    = 1'b1;
              state_d = ST_BIT_LO;
            end
          endcase
        end
      end
      ST_RS_LO, ST_BIT_LO, ST_STOP_LO: begin
        // Second part of the low phase, then release the clock.
        if (hit(cnt_q, `T_SCL_LOW_CYC - `T_DATA_CYC)) begin
          scl_d   = 1'b0;
          state_d = (state_q == ST_RS_LO) ? ST_START_SU :
                    (state_q == ST_BIT_LO) ? ST_BIT_HI : ST_STOP_SU;
        end
      end
      ST_BIT_HI: begin
        if (hit(cnt_q, `T_DATA_CYC) && rd_q) begin
          rd_d   = 1'b0;
          done_d = 1'b1;
          rsp_d  = '{rbit: sda_lvl, err: 1'b0};
        end
        if (hit(cnt_q, `T_SCL_HIGH_CYC)) begin
          scl_d   = 1'b1;
          state_d = ST_LOW;
        end
      end
      ST_STOP_SU: begin
        if (hit(cnt_q, `T_SU_STO_CYC)) begin
          sda_d   = 1'b0;
          state_d = ST_BUS_FREE;
        end
      end
      ST_BUS_FREE: begin
        // No START is looked at until the free time has passed.
        if (hit(cnt_q, `T_BUF_CYC)) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  // Timer registers; reset leaves both lines released and the counter idle.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q   <= ST_IDLE;
      cnt_q     <= '0;
      scl_drv_q <= 1'b0;
      sda_drv_q <= 1'b0;
      rd_q      <= 1'b0;
      done_q    <= 1'b0;
      rsp_q     <= '0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      scl_drv_q <= scl_d;
      sda_drv_q <= sda_d;
      rd_q      <= rd_d;
      done_q    <= done_d;
      rsp_q     <= rsp_d;
    end
  end

  // Pending command. An arrival wins over the consume of the previous one.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pend_q <= 1'b0;
      cmd_q  <= '0;
    end else begin
      pend_q <= new_cmd | (pend_q & ~take);
      if (new_cmd) begin
        cmd_q <= new_cmd_val;
      end
    end
  end

endmodule // i2c_bit_timer

/* File: tb/i2c_target_model.sv */
// Behavioural two-wire target that answers read bits.
`timescale 1ns/1ps
module i2c_target_model (
  // Serial clock level on the wire.
  input  wire logic scl_i,
  // Drive enable, bit to return, slow answer.
  input  wire logic en_i,
  input  wire logic bit_i,
  input  wire logic slow_i,
  // High while the data line is pulled low.
  output logic      pull_o
);
  initial pull_o = 1'b0;
  // Let go at each clock fall, drive from within the low phase until the next fall, so a slow answer tests the sample point.
  always @(negedge scl_i) begin
    pull_o = 1'b0;
    #(slow_i ? 4000 : 50);
    pull_o = en_i & ~bit_i;
  end
endmodule // i2c_target_model

/* File: tb/i2c_bit_timer_assertions.sv */
// Port checks for the serial bit timer.
`timescale 1ns/1ps
module i2c_bit_timer_assertions (
  // Clocks and reset.
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic CMD_CLK_I,
  // Command handshake.
  input wire logic CMD_VALID_I,
  input wire logic CMD_READY_O,
  input wire logic RSP_VALID_O,
  // Pin enables.
  input wire logic SCL_OE_N_O,
  input wire logic SDA_OE_N_O
);
  logic        scl_q, sda_q;     // Enables one cycle back.
  logic [11:0] scl_cnt, sda_cnt; // Cycles since each enable changed; saturates.
  // Reset counts as a long idle bus.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      scl_cnt <= 12'hfff;
      sda_cnt <= 12'hfff;
    end else begin
      scl_q   <= SCL_OE_N_O;
      sda_q   <= SDA_OE_N_O;
      scl_cnt <= (SCL_OE_N_O != scl_q) ? 12'h001 : scl_cnt + {11'h000, ~&scl_cnt};
      sda_cnt <= (SDA_OE_N_O != sda_q) ? 12'h001 : sda_cnt + {11'h000, ~&sda_cnt};
    end
  end
  // Data pulled low while the clock is high.
  sequence s_start;
    $fell(SDA_OE_N_O) && SCL_OE_N_O;
  endsequence
  AST_SCL_HIGH: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $fell(SCL_OE_N_O) |-> scl_cnt == 12'd512 || (!SDA_OE_N_O && sda_cnt == 12'd512 && scl_cnt >= 12'd1536))
    else $error("clock high phase wrong");
  AST_SCL_LOW: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $rose(SCL_OE_N_O) |-> scl_cnt >= 12'd512) else $error("clock low phase short");
  AST_STOP_SETUP: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $rose(SDA_OE_N_O) && SCL_OE_N_O |-> scl_cnt == 12'd512) else $error("stop setup wrong");
  AST_START_SETUP: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    s_start |-> scl_cnt >= 12'd1024 && sda_cnt >= 12'd512) else $error("start setup or bus free short");
  AST_START_HOLD: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    s_start |-> !SDA_OE_N_O throughout (##[1:520] $fell(SCL_OE_N_O))) else $error("start hold wrong");
  AST_DATA_POINT: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $changed(SDA_OE_N_O) && !SCL_OE_N_O |-> scl_cnt == 12'd256) else $error("data change off point");
  AST_RESET_IDLE: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $fell(RST_I) |-> SCL_OE_N_O && SDA_OE_N_O) else $error("lines not released after reset");
  AST_READY_DROP: assert property (@(posedge CMD_CLK_I) disable iff (RST_I)
    CMD_VALID_I && CMD_READY_O |=> !CMD_READY_O) else $error("ready stays high after take");
  AST_RSP_PULSE: assert property (@(posedge CMD_CLK_I) disable iff (RST_I)
    RSP_VALID_O |=> !RSP_VALID_O && CMD_READY_O) else $error("answer pulse wrong");
endmodule // i2c_bit_timer_assertions
bind i2c_bit_timer i2c_bit_timer_assertions chk (.REF_CLK_I, .RST_I, .CMD_CLK_I, .CMD_VALID_I,
  .CMD_READY_O, .RSP_VALID_O, .SCL_OE_N_O, .SDA_OE_N_O);

/* File: tb/test_i2c_bit_timer.sv */
// Self-checking bench for the serial bit timer.
`timescale 1ns/1ps
module test_i2c_bit_timer;
  import i2c_timing_pkg::*;
  logic     ref_clk, cmd_clk, rst, valid, ready, rsp_v;
  logic     scl_oe_n, sda_oe_n, scl_o, sda_o, en, tbit, slow, pull, last_bit;
  bit_cmd_s cmd;
  bit_rsp_s rsp;
  wire      scl_w, sda_w;
  time      fall_t, fall_prev, rise_t, stop_gap; // Wire event times.
  int       fail_count, n_tests, cyc;
  // Pull-ups on both lines.
  assign scl_w = scl_oe_n ? 1'b1 : scl_o;
  assign sda_w = (sda_oe_n ? 1'b1 : sda_o) & ~pull;
  i2c_bit_timer dut (.REF_CLK_I(ref_clk), .RST_I(rst), .CMD_CLK_I(cmd_clk), .CMD_VALID_I(valid),
    .CMD_READY_O(ready), .CMD_I(cmd), .RSP_VALID_O(rsp_v), .RSP_O(rsp), .SCL_I(scl_w), .SCL_O(scl_o),
    .SCL_OE_N_O(scl_oe_n), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n));
  i2c_target_model tgt (.scl_i(scl_w), .en_i(en), .bit_i(tbit), .slow_i(slow), .pull_o(pull));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Link clock, offset so its edges never line up with the host clock.
  initial begin
    cmd_clk = 1'b0;
    #1.7;
    forever #3 cmd_clk = ~cmd_clk;
  end
  // Record clock edges and the bit the target sees.
  always @(negedge scl_w) begin
    fall_prev = fall_t;
    fall_t    = $time;
  end
  always @(posedge scl_w) begin
    rise_t   = $time;
    last_bit = sda_w;
  end
  always @(posedge sda_w) if (scl_w === 1'b1) stop_gap = $time - rise_t;
  // Cut a hang short.
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      fail_count = fail_count + 1;
      tally_and_finish();
    end
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value %s: expected %0d, seen %0d", name, exp, got);
    end
  endtask
  // Hold the request until taken, then wait for the answer pulse.
  task automatic send(input bit_op_e op, input logic wb);
    int n;
    @(negedge cmd_clk);
    valid = 1'b1;
    cmd   = '{op: op, wbit: wb};
    for (n = 0; n < 5000 && ready !== 1'b1; n++) @(negedge cmd_clk);
    @(negedge cmd_clk);
    valid = 1'b0;
    for (n = 0; n < 9000 && rsp_v !== 1'b1; n++) @(negedge cmd_clk);
    // A lost answer must not slip through as a quiet timeout.
    check("answer pulse", 1, rsp_v);
  endtask
  task automatic t_reset();
    check("scl_oe_n", 1, scl_oe_n);
    check("sda_oe_n", 1, sda_oe_n);
  endtask
  // A data bit outside a transfer is refused.
  task automatic t_idle();
    send(OP_WRITE, 1'b1);
    check("err", 1, rsp.err);
  endtask
  task automatic t_write();
    send(OP_START, 1'b0);
    send(OP_WRITE, 1'b1);
    send(OP_WRITE, 1'b0);
    check("write bit", 1, last_bit);
    send(OP_STOP, 1'b0);
    check("write bit", 0, last_bit);
    check("period ns", 10240, 32'(fall_t - fall_prev));
    check("high ns", 5120, 32'(fall_t - rise_t));
    repeat (1200) @(negedge ref_clk);
    check("stop setup ns", 5120, 32'(stop_gap));
  endtask
  // Prompt then slow target answers, then a repeated start.
  task automatic t_read();
    send(OP_START, 1'b0);
    {en, tbit, slow} = 3'b110;
    send(OP_READ, 1'b0);
    check("read bit", 1, rsp.rbit);
    {en, tbit, slow} = 3'b101;
    send(OP_READ, 1'b0);
    check("read bit", 0, rsp.rbit);
    en = 1'b0;
    send(OP_START, 1'b0);
    send(OP_WRITE, 1'b0);
    send(OP_STOP, 1'b0);
    repeat (1200) @(negedge ref_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    rst   = 1'b1;
    valid = 1'b0;
    cmd   = '0;
    {en, tbit, slow} = 3'b000;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    t_reset();
    t_idle();
    t_write();
    t_read();
    tally_and_finish();
  end
endmodule // test_i2c_bit_timer
